// ### inc/wdctl_consts.svh
// constants for the watchdog control register block
`ifndef WDCTL_CONSTS_SVH
`define WDCTL_CONSTS_SVH
// ****************************************
// register map
// ****************************************
`define WDCTL_CTRL_ADDR 12'h000
`define WDCTL_ADDR_W 12
// ****************************************
// field positions
// ****************************************
`define WDCTL_ON_BIT 15
`define WDCTL_PS_HI 6
`define WDCTL_PS_LO 2
`define WDCTL_WIN_BIT 1
`define WDCTL_CLR_BIT 0
`define WDCTL_PS_W 5
// ****************************************
// reset values
// ****************************************
`define WDCTL_SW_ON_RST 1'h0
`define WDCTL_WIN_RST 1'h0
`define WDCTL_PS_RST 5'h00
// ****************************************
// timing counts
// ****************************************
// edges after release until the synchronised postscaler is loaded
`define WDCTL_LOAD_WAIT 2'h3
`endif

// ### inc/wdctl_pkg.sv
// types for the watchdog control register block
package wdctl_pkg;
   // apb request bundle from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } wdctl_apb_req_t;
   // control outputs toward the watchdog timer
   typedef struct packed {
      logic running;
      logic window_mode_enable;
      logic counter_clear;
   } wdctl_ctl_t;
endpackage

// ### src/wdctl_top.sv
// watchdog control register with apb slave
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "wdctl_consts.svh"
module wdctl_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire wdctl_pkg::wdctl_apb_req_t apb_req,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic fuse_enable,
   input wire logic [4:0] config_postscaler,
   output var wdctl_pkg::wdctl_ctl_t ctl
);
   // ****************************************
   // decoding
   // ****************************************
   // true when the address hits the control word
   function automatic logic hit_ctrl(input logic [11:0] a);
      hit_ctrl = (a == `WDCTL_CTRL_ADDR);
   endfunction

   logic fuse_meta; // first sync stage, read only by fuse_sync
   logic fuse_sync; // fuse enable in pclk domain
   logic [4:0] ps_meta; // first sync stage of the postscaler
   logic [4:0] ps_sync; // postscaler in pclk domain
   logic sw_on; // software enable
   logic window_en; // window mode
   logic [4:0] postscaler_shadow; // read-only shadow
   logic [1:0] load_cnt; // edges left until the shadow loads
   logic clear_pulse; // one-cycle counter clear
   logic wr_acc; // write access phase
   logic rd_acc; // read access phase
   logic wr_hit; // write to control word

   // zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign wr_acc = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_acc = apb_req.psel & apb_req.penable & ~apb_req.pwrite;
   assign wr_hit = wr_acc & hit_ctrl(apb_req.paddr);
   // unmapped addresses answer with an error
   assign pslverr = apb_req.psel & apb_req.penable & ~hit_ctrl(apb_req.paddr);

   // ****************************************
   // synchronisers for the strap inputs
   // ****************************************
   // fuse settings arrive from outside the clock domain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fuse_meta <= 1'b0;
         fuse_sync <= 1'b0;
         ps_meta <= `WDCTL_PS_RST;
         ps_sync <= `WDCTL_PS_RST;
      end else begin
         fuse_meta <= fuse_enable;
         fuse_sync <= fuse_meta;
         ps_meta <= config_postscaler;
         ps_sync <= ps_meta;
      end
   end

   // ****************************************
   // postscaler shadow
   // ****************************************
   // caught after release, once the sync chain has filled; the
   // trade-off is three cycles where the field still reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         postscaler_shadow <= `WDCTL_PS_RST;
         load_cnt <= `WDCTL_LOAD_WAIT;
      end else begin
         if (load_cnt != 2'h0) begin
            load_cnt <= load_cnt - 2'h1;
         end
         // last count step: the second stage holds the strap value
         if (load_cnt == 2'h1) begin
            postscaler_shadow <= ps_sync;
         end
      end
   end

   // ****************************************
   // enables
   // ****************************************
   // software on bit; a zero write only drops the software request,
   // a fuse-enabled watchdog keeps running regardless
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sw_on <= `WDCTL_SW_ON_RST;
         window_en <= `WDCTL_WIN_RST;
      end else if (wr_hit) begin
         sw_on <= apb_req.pwdata[`WDCTL_ON_BIT];
         window_en <= apb_req.pwdata[`WDCTL_WIN_BIT];
      end
   end

   // ****************************************
   // counter clear strobe
   // ****************************************
   // pulse only on a one; a zero write leaves nothing behind
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clear_pulse <= 1'b0;
      end else begin
         clear_pulse <= wr_hit & apb_req.pwdata[`WDCTL_CLR_BIT];
      end
   end

   // ****************************************
   // read data
   // ****************************************
   // registered so data comes from a flip-flop; updated each cycle
   // of setup so it is valid in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= 32'h0000_0000;
         if (apb_req.psel && !apb_req.penable && hit_ctrl(apb_req.paddr)) begin
            prdata[`WDCTL_ON_BIT] <= sw_on | fuse_sync;
            prdata[`WDCTL_PS_HI:`WDCTL_PS_LO] <= postscaler_shadow;
            prdata[`WDCTL_WIN_BIT] <= window_en;
         end
      end
   end

   // ****************************************
   // control outputs
   // ****************************************
   // running is on with the fuse or the software bit; a late disable is harmless here
   assign ctl = '{
      running: sw_on | fuse_sync,
      window_mode_enable: window_en,
      counter_clear: clear_pulse
   };

   // ****************************************
   // assertions
   // ****************************************
   // a one on the enable bit shows up as running next cycle
   AST_ON_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
      wr_hit && apb_req.pwdata[`WDCTL_ON_BIT] |=> ctl.running)
      else $error("watchdog not running after enable write");
   // a software stop takes effect unless the fuse holds it on
   AST_SW_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      wr_hit && !apb_req.pwdata[`WDCTL_ON_BIT] && !fuse_sync ##1 !fuse_sync
      |-> !ctl.running)
      else $error("software disable did not stop watchdog");
   // a zero write cannot stop a fuse-enabled watchdog
   AST_FUSE_KEEPS: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_sync && wr_hit && !apb_req.pwdata[`WDCTL_ON_BIT] ##1 fuse_sync
      |-> ctl.running)
      else $error("fuse-enabled watchdog stopped");
   // the read word reports the running state
   AST_RD_ON: assert property (@(posedge pclk) disable iff (!presetn)
      apb_req.psel && !apb_req.penable && hit_ctrl(apb_req.paddr) && ctl.running
      |=> prdata[`WDCTL_ON_BIT])
      else $error("enable bit read zero while running");
   // shadow takes the synchronised strap value at the last count step
   AST_PS_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      load_cnt == 2'h1 |=> postscaler_shadow == $past(ps_sync))
      else $error("postscaler shadow not loaded");
   // once loaded the shadow is read-only until the next reset
   AST_PS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      load_cnt == 2'h0 |=> $stable(postscaler_shadow))
      else $error("postscaler shadow changed after load");
   // window bit follows the written value
   AST_WIN: assert property (@(posedge pclk) disable iff (!presetn)
      wr_hit |=> ctl.window_mode_enable == $past(apb_req.pwdata[`WDCTL_WIN_BIT]))
      else $error("window enable not written");
   // a one write gives exactly one clear cycle
   AST_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      wr_hit && apb_req.pwdata[`WDCTL_CLR_BIT] |=> ctl.counter_clear ##1
      !ctl.counter_clear)
      else $error("counter clear pulse wrong");
   // no clear without a one write
   AST_CLR_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_hit && apb_req.pwdata[`WDCTL_CLR_BIT]) |=> !ctl.counter_clear)
      else $error("counter clear without one write");
   // unimplemented bits never read back as one
   AST_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
      prdata[31:16] == 16'h0000 && prdata[14:7] == 8'h00 && prdata[0] == 1'b0)
      else $error("unimplemented bits read nonzero");
   // writes to any other address leave the enables alone
   AST_UNMAPPED_WR: assert property (@(posedge pclk) disable iff (!presetn)
      wr_acc && !hit_ctrl(apb_req.paddr)
      |=> $stable(sw_on) && $stable(window_en))
      else $error("unmapped write changed an enable");
   // read data is zero outside a setup-to-access pair
   AST_RD_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
      !(apb_req.psel && !apb_req.penable) |=> prdata == 32'h0000_0000)
      else $error("read data not zero outside a read");
   // both enables start from zero
   AST_RST: assert property (@(posedge pclk) $rose(presetn) |->
      !sw_on && !window_en)
      else $error("enables not zero after reset");

   // ****************************************
   // cover points
   // ****************************************
   // main scenarios: start, stop, clear, fuse hold, mapped read
   COV_SW_START: cover property (@(posedge pclk) disable iff (!presetn)
      !ctl.running ##1 ctl.running);
   COV_SW_STOP: cover property (@(posedge pclk) disable iff (!presetn)
      ctl.running ##1 !ctl.running);
   COV_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
      ctl.counter_clear);
   COV_FUSE_HOLD: cover property (@(posedge pclk) disable iff (!presetn)
      fuse_sync && wr_hit && !apb_req.pwdata[`WDCTL_ON_BIT]);
   COV_READ: cover property (@(posedge pclk) disable iff (!presetn)
      rd_acc && hit_ctrl(apb_req.paddr));
endmodule // wdctl_top
`default_nettype wire

// ### test/wdctl_tb.sv
// self-checking testbench for the watchdog control register
`timescale 1ns/100ps
`default_nettype none
module testbench;
   // ****************************************
   // bench signals
   // ****************************************
   logic pclk; // 50 ns bus clock
   logic presetn; // active-low reset
   wdctl_pkg::wdctl_apb_req_t req; // apb request bundle
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic fuse_enable; // config fuse enable
   logic [4:0] config_postscaler; // config postscaler value
   wdctl_pkg::wdctl_ctl_t ctl;
   int bad_count;
   int cmp_count;
   int cycles; // timeout counter
   logic [31:0] rd; // last read data
   logic err; // last slave error
   wdctl_top u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .fuse_enable(fuse_enable),
      .config_postscaler(config_postscaler), .ctl(ctl));
   // ****************************************
   // clock and timeout
   // ****************************************
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   // whole run needs under a hundred cycles, so 5000 means a hang
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         bad_count++;
         finish_test();
      end
   end
   // ****************************************
   // tasks
   // ****************************************
   // closing report and verdict
   task automatic finish_test();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one comparison
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask
   // expected register word
   function automatic logic [31:0] word(input logic on, input logic [4:0] ps, input logic win);
      return {16'h0000, on, 8'h00, ps, win, 1'b0};
   endfunction
   // one apb transfer; leading edge keeps a gap so nothing is driven twice at one edge
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
      @(posedge pclk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= addr;
      req.pwdata <= wdata;
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      // only the bench timeout ends a wait for the answer
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // write at offset zero, then watch the clear pulse for two cycles
   task automatic wr_chk(input logic [31:0] d, input logic pulse);
      apb(1'b1, 12'h000, d);
      #1;
      chk("clear pulse", {31'h0, pulse}, {31'h0, ctl.counter_clear});
      @(posedge pclk);
      #1;
      chk("clear end", 32'h0, {31'h0, ctl.counter_clear});
   endtask
   // reset with a given config postscaler held well before release
   task automatic do_reset(input logic [4:0] ps);
      config_postscaler <= ps;
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      // shadow loads at the third edge after release
      repeat (4) @(posedge pclk);
   endtask
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      presetn = 1'b0;
      req = '0;
      fuse_enable = 1'b0;
      config_postscaler = 5'h15;
      bad_count = 0;
      cmp_count = 0;
      cycles = 0;
      do_reset(5'h15);
      apb(1'b0, 12'h000, 32'h0);
      chk("reset word", word(1'b0, 5'h15, 1'b0), rd);
      chk("mapped err", 32'h0, {31'h0, err});
      wr_chk(32'hFFFF_FFFF, 1'b1);
      chk("sw start", 32'h1, {31'h0, ctl.running});
      chk("window on", 32'h1, {31'h0, ctl.window_mode_enable});
      apb(1'b0, 12'h000, 32'h0);
      chk("set word", word(1'b1, 5'h15, 1'b1), rd);
      wr_chk(32'h0000_0000, 1'b0);
      chk("sw stop", 32'h0, {31'h0, ctl.running});
      chk("window off", 32'h0, {31'h0, ctl.window_mode_enable});
      // two idle cycles before the next access after disabling
      apb(1'b0, 12'h000, 32'h0);
      chk("cleared word", word(1'b0, 5'h15, 1'b0), rd);
      fuse_enable <= 1'b1;
      repeat (4) @(posedge pclk);
      #1;
      chk("fuse run", 32'h1, {31'h0, ctl.running});
      wr_chk(32'h0000_0000, 1'b0);
      chk("fuse keeps", 32'h1, {31'h0, ctl.running});
      apb(1'b0, 12'h000, 32'h0);
      chk("fuse word", word(1'b1, 5'h15, 1'b0), rd);
      apb(1'b1, 12'h004, 32'hFFFF_FFFF);
      chk("unmapped wr err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h004, 32'h0);
      chk("unmapped rd", 32'h0, rd);
      apb(1'b0, 12'h000, 32'h0);
      chk("after unmapped", word(1'b1, 5'h15, 1'b0), rd);
      fuse_enable <= 1'b0;
      do_reset(5'h0A);
      apb(1'b0, 12'h000, 32'h0);
      chk("second reset", word(1'b0, 5'h0A, 1'b0), rd);
      finish_test();
   end
endmodule // testbench
`default_nettype wire
